// ### hdl/msd_defs.svh
// Contract
// (RQ1) Request code 71 selects display/operating mode
// (RQ2) Mode byte: 00, 01, 09, 0A supported
// (RQ3) Valid command switches both modes at once
// (RQ4) Mode held until new command or reset
// (RQ5) Requester fills bytes three to eight FF
// (RQ6) Unsupported mode byte ignored, mode unchanged
`ifndef MSD_DEFS_SVH
`define MSD_DEFS_SVH

// ==========================================================
// Message layout
`define MSD_REQ_MODE_SEL   8'h71
`define MSD_FILL_BYTE      8'hff
`define MSD_B1_MSB         63
`define MSD_B1_LSB         56
`define MSD_B2_MSB         55
`define MSD_B2_LSB         48
`define MSD_FILL_MSB       47
`define MSD_FILL_LSB       0
`define MSD_FILL_BYTES     6

// ==========================================================
// Mode codes
`define MSD_MODE_NORMAL    8'h00
`define MSD_MODE_DIAG      8'h01
`define MSD_MODE_CALIB     8'h09
`define MSD_MODE_ERROR     8'h0a
`define MSD_MODE_RESET     8'h00

`endif

// ### hdl/msd_pkg.sv
`include "msd_defs.svh"

package msd_pkg;
  typedef enum logic [3:0] {
    MSD_DISP_NORMAL = 4'h1,
    MSD_DISP_DIAG   = 4'h2,
    MSD_DISP_CALIB  = 4'h4,
    MSD_DISP_ERROR  = 4'h8
  } msd_disp_e;

  typedef enum logic [1:0] {
    MSD_OP_NORMAL = 2'h1,
    MSD_OP_CALIB  = 2'h2
  } msd_op_e;
endpackage

// ### hdl/msd_mode_select_decoder.sv
`timescale 1ns/1ns
`include "msd_defs.svh"

module msd_mode_select_decoder
  import msd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        host_request_valid,
  input  wire logic [63:0] host_request_message,
  output logic [7:0]       mode_code,
  output msd_disp_e        disp_mode,
  output msd_op_e          op_mode,
  output logic             mode_changed,
  output logic             fill_error
);

  // ==========================================================
  // Decode
  logic [7:0] req_byte;
  logic [7:0] mode_byte;
  logic       is_mode_req;
  logic       mode_ok;
  logic       take;
  logic       fill_bad;

  assign req_byte    = host_request_message[`MSD_B1_MSB:`MSD_B1_LSB];
  assign mode_byte   = host_request_message[`MSD_B2_MSB:`MSD_B2_LSB];
  assign is_mode_req = host_request_valid && (req_byte == `MSD_REQ_MODE_SEL); // [RQ1]
  assign mode_ok     = (mode_byte == `MSD_MODE_NORMAL) || (mode_byte == `MSD_MODE_DIAG)
                    || (mode_byte == `MSD_MODE_CALIB) || (mode_byte == `MSD_MODE_ERROR); // [RQ2]
  // Fill bytes are not checked for acceptance; senders may be lax
  assign take        = is_mode_req && mode_ok; // [RQ6]
  assign fill_bad    = (host_request_message[`MSD_FILL_MSB:`MSD_FILL_LSB]
                     != {`MSD_FILL_BYTES{`MSD_FILL_BYTE}}); // [RQ5]

  // ==========================================================
  // Mode register
  logic [7:0] mode_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= `MSD_MODE_RESET; // [RQ4]
    end else if (take) begin
      mode_ff <= mode_byte; // [RQ3]
    end
  end

  assign mode_code = mode_ff;

  // ==========================================================
  // Display and operating mode registers
  // Decoded from the incoming byte so both outputs come from flops
  msd_disp_e nxt_disp;
  msd_op_e   nxt_op;
  msd_disp_e disp_ff;
  msd_op_e   op_ff;

  always_comb begin
    case (mode_byte)
      `MSD_MODE_NORMAL: begin
        nxt_disp = MSD_DISP_NORMAL;
        nxt_op   = MSD_OP_NORMAL;
      end
      `MSD_MODE_DIAG: begin
        nxt_disp = MSD_DISP_DIAG;
        nxt_op   = MSD_OP_NORMAL;
      end
      `MSD_MODE_CALIB: begin
        nxt_disp = MSD_DISP_CALIB;
        nxt_op   = MSD_OP_CALIB;
      end
      `MSD_MODE_ERROR: begin
        nxt_disp = MSD_DISP_ERROR;
        nxt_op   = MSD_OP_NORMAL;
      end
      default: begin
        nxt_disp = MSD_DISP_NORMAL;
        nxt_op   = MSD_OP_NORMAL;
      end
    endcase
  end

  // Same strobe loads both, so display and operation never disagree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      disp_ff <= MSD_DISP_NORMAL; // [RQ4]
    end else if (take) begin
      disp_ff <= nxt_disp; // [RQ3]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_ff <= MSD_OP_NORMAL; // [RQ4]
    end else if (take) begin
      op_ff <= nxt_op; // [RQ3]
    end
  end

  assign disp_mode = disp_ff;
  assign op_mode   = op_ff;

  // ==========================================================
  // Status pulses
  logic changed_ff;
  logic fill_err_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      changed_ff <= 1'b0;
    end else begin
      changed_ff <= take && (mode_byte != mode_ff);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_err_ff <= 1'b0;
    end else begin
      fill_err_ff <= is_mode_req && fill_bad; // [RQ5]
    end
  end

  assign mode_changed = changed_ff;
  assign fill_error   = fill_err_ff;

  // ==========================================================
  // Checks
  property p_take_updates;
    @(posedge clk) disable iff (rst)
      take |=> (mode_code == $past(mode_byte));
  endproperty
  a_take_updates: assert property (p_take_updates) else $error("mode not taken"); // [RQ3]

  property p_hold;
    @(posedge clk) disable iff (rst)
      !take |=> $stable(mode_code);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed without command"); // [RQ4]

  property p_bad_ignored;
    @(posedge clk) disable iff (rst)
      (is_mode_req && !mode_ok) |=> $stable(mode_code);
  endproperty
  a_bad_ignored: assert property (p_bad_ignored) else $error("bad mode accepted"); // [RQ6]

  property p_other_code;
    @(posedge clk) disable iff (rst)
      (host_request_valid && req_byte != `MSD_REQ_MODE_SEL) |=> $stable(mode_code);
  endproperty
  a_other_code: assert property (p_other_code) else $error("other request changed mode"); // [RQ1]

  property p_calib_pair;
    @(posedge clk) disable iff (rst)
      (op_mode == MSD_OP_CALIB) == (disp_mode == MSD_DISP_CALIB);
  endproperty
  a_calib_pair: assert property (p_calib_pair) else $error("modes disagree"); // [RQ2]

  property p_legal;
    @(posedge clk) disable iff (rst)
      mode_code inside {`MSD_MODE_NORMAL, `MSD_MODE_DIAG, `MSD_MODE_CALIB, `MSD_MODE_ERROR};
  endproperty
  a_legal: assert property (p_legal) else $error("illegal mode held"); // [RQ2]

  property p_disp_onehot;
    @(posedge clk) disable iff (rst)
      $onehot(disp_mode);
  endproperty
  a_disp_onehot: assert property (p_disp_onehot) else $error("display not one-hot"); // [RQ2]

  property p_op_onehot;
    @(posedge clk) disable iff (rst)
      $onehot(op_mode);
  endproperty
  a_op_onehot: assert property (p_op_onehot) else $error("operation not one-hot"); // [RQ2]

  property p_normal_map;
    @(posedge clk) disable iff (rst)
      (mode_code == `MSD_MODE_NORMAL)
        |-> (disp_mode == MSD_DISP_NORMAL) && (op_mode == MSD_OP_NORMAL);
  endproperty
  a_normal_map: assert property (p_normal_map) else $error("normal decode wrong"); // [RQ2]

  property p_diag_map;
    @(posedge clk) disable iff (rst)
      (mode_code == `MSD_MODE_DIAG)
        |-> (disp_mode == MSD_DISP_DIAG) && (op_mode == MSD_OP_NORMAL);
  endproperty
  a_diag_map: assert property (p_diag_map) else $error("diagnostic decode wrong"); // [RQ2]

  property p_calib_map;
    @(posedge clk) disable iff (rst)
      (mode_code == `MSD_MODE_CALIB)
        |-> (disp_mode == MSD_DISP_CALIB) && (op_mode == MSD_OP_CALIB);
  endproperty
  a_calib_map: assert property (p_calib_map) else $error("calibration decode wrong"); // [RQ2]

  property p_error_map;
    @(posedge clk) disable iff (rst)
      (mode_code == `MSD_MODE_ERROR)
        |-> (disp_mode == MSD_DISP_ERROR) && (op_mode == MSD_OP_NORMAL);
  endproperty
  a_error_map: assert property (p_error_map) else $error("error decode wrong"); // [RQ2]

  property p_both_switch;
    @(posedge clk) disable iff (rst)
      take |=> (disp_mode == $past(nxt_disp)) && (op_mode == $past(nxt_op));
  endproperty
  a_both_switch: assert property (p_both_switch) else $error("modes not switched"); // [RQ3]

  property p_changed_cause;
    @(posedge clk) disable iff (rst)
      mode_changed |-> $past(take);
  endproperty
  a_changed_cause: assert property (p_changed_cause) else $error("pulse without command"); // [RQ3]

  property p_changed_diff;
    @(posedge clk) disable iff (rst)
      mode_changed |-> (mode_code != $past(mode_code));
  endproperty
  a_changed_diff: assert property (p_changed_diff) else $error("pulse without change"); // [RQ3]

  property p_quiet_pulse;
    @(posedge clk) disable iff (rst)
      !take |=> !mode_changed;
  endproperty
  a_quiet_pulse: assert property (p_quiet_pulse) else $error("stray change pulse"); // [RQ4]

  property p_fill_flag;
    @(posedge clk) disable iff (rst)
      (is_mode_req && fill_bad) |=> fill_error;
  endproperty
  a_fill_flag: assert property (p_fill_flag) else $error("bad fill not flagged"); // [RQ5]

  property p_fill_quiet;
    @(posedge clk) disable iff (rst)
      !(is_mode_req && fill_bad) |=> !fill_error;
  endproperty
  a_fill_quiet: assert property (p_fill_quiet) else $error("stray fill flag"); // [RQ5]

endmodule

// ### bench/msd_host_model.sv
`timescale 1ns/1ns
// ====
// Vehicle controller side
module msd_host_model (
  input  wire logic        clk,
  output logic             valid,
  output logic [63:0]      msg
);
  initial begin
    valid = 1'b0;
    msg   = 64'h0;
  end
  // Normal sends go through send_fill with the FF fill; direct send_fill calls are for fault cases
  task automatic send_fill(input logic [7:0] code, input logic [7:0] mode,
                           input logic [47:0] fill);
    @(posedge clk);
    #5 valid = 1'b1;
    msg = {code, mode, fill};
    @(posedge clk);
    #5 valid = 1'b0;
    // Idle word inverted so stale data is never trusted
    msg = ~msg;
  endtask
  task automatic send(input logic [7:0] code, input logic [7:0] mode);
    send_fill(code, mode, 48'hffffffffffff);
  endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import msd_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        valid;
  logic [63:0] msg;
  logic [7:0]  code;
  msd_disp_e   disp;
  msd_op_e     op;
  logic        chg;
  logic        ferr;
  int          err_total = 0;
  int          cmp_count = 0;
  always #25 clk = ~clk;
  msd_host_model host_u (.clk(clk), .valid(valid), .msg(msg));
  msd_mode_select_decoder dut_u (.clk(clk), .rst(rst), .host_request_valid(valid),
    .host_request_message(msg), .mode_code(code), .disp_mode(disp), .op_mode(op),
    .mode_changed(chg), .fill_error(ferr));
  // ====
  // Checking
  task automatic chk(input logic [14:0] exp);
    cmp_count++;
    if ({code, disp, op, chg} !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, {code, disp, op, chg}, exp);
    end
  endtask
  task automatic chk_fill(input logic exp);
    cmp_count++;
    if (ferr !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, ferr, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic test_modes();
    host_u.send(8'h71, 8'h01);
    chk({8'h01, 4'h2, 2'h1, 1'b1});
    host_u.send(8'h71, 8'h09);
    chk({8'h09, 4'h4, 2'h2, 1'b1});
    host_u.send(8'h71, 8'h0a);
    chk({8'h0a, 4'h8, 2'h1, 1'b1});
    host_u.send(8'h71, 8'h00);
    chk({8'h00, 4'h1, 2'h1, 1'b1});
    $display("test_modes finished");
  endtask
  task automatic test_refuse();
    host_u.send(8'h70, 8'h09);
    chk({8'h00, 4'h1, 2'h1, 1'b0});
    host_u.send(8'h71, 8'h02);
    chk({8'h00, 4'h1, 2'h1, 1'b0});
    host_u.send(8'h71, 8'h0b);
    chk({8'h00, 4'h1, 2'h1, 1'b0});
    $display("test_refuse finished");
  endtask
  task automatic test_hold_reset();
    host_u.send(8'h71, 8'h09);
    repeat (3) @(posedge clk);
    #5 chk({8'h09, 4'h4, 2'h2, 1'b0});
    rst = 1'b1;
    #1 chk({8'h00, 4'h1, 2'h1, 1'b0});
    @(posedge clk);
    #5 rst = 1'b0;
    host_u.send(8'h71, 8'h0a);
    chk({8'h0a, 4'h8, 2'h1, 1'b1});
    $display("test_hold_reset finished");
  endtask
  task automatic test_fill();
    host_u.send_fill(8'h71, 8'h01, 48'hffffffffff00);
    chk({8'h01, 4'h2, 2'h1, 1'b1});
    chk_fill(1'b1);
    host_u.send(8'h71, 8'h01);
    chk({8'h01, 4'h2, 2'h1, 1'b0});
    chk_fill(1'b0);
    host_u.send_fill(8'h71, 8'h02, 48'h00ffffffffff);
    chk({8'h01, 4'h2, 2'h1, 1'b0});
    chk_fill(1'b1);
    host_u.send_fill(8'h70, 8'h09, 48'h000000000000);
    chk({8'h01, 4'h2, 2'h1, 1'b0});
    chk_fill(1'b0);
    $display("test_fill finished");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #5 rst = 1'b0;
    test_modes();
    test_refuse();
    test_hold_reset();
    test_fill();
    end_of_test();
  end
  // Run needs about 38 cycles
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
endmodule
